/* dsc_pkg.sv */
package dsc_pkg;
	localparam int ADDR_W = 20;
	localparam int CHR_AW = 16;
	localparam int RAS_W = 5;
	localparam int HC_W = 8;
	localparam int VC_W = 10;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_HTIME = 8'h04;
	localparam logic [7:0] OFS_VTIME = 8'h08;
	localparam logic [7:0] OFS_SPLIT = 8'h0c;
	localparam logic [7:0] OFS_WINH = 8'h10;
	localparam logic [7:0] OFS_WINV = 8'h14;
	localparam logic [7:0] OFS_ZOOM = 8'h18;
	localparam logic [7:0] OFS_BCUR_A = 8'h1c;
	localparam logic [7:0] OFS_BPOS_A = 8'h20;
	localparam logic [7:0] OFS_BCUR_B = 8'h24;
	localparam logic [7:0] OFS_BPOS_B = 8'h28;
	localparam logic [7:0] OFS_GCUR_X = 8'h2c;
	localparam logic [7:0] OFS_GCUR_Y = 8'h30;
	localparam logic [7:0] OFS_STAT = 8'h34;
	localparam logic [7:0] OFS_LPEN = 8'h38;
	// Screen i: start address at 0x40 + 8*i, config word at 0x44 + 8*i
	localparam logic [7:0] OFS_SCR_BASE = 8'h40;

	// Control register fields
	localparam int CTL_EN_LSB = 0;
	localparam int CTL_BLANK_LSB = 4;
	localparam int CTL_CHR_LSB = 8;
	localparam int CTL_CMODE_LSB = 12;
	localparam int CTL_SCAN_LSB = 14;
	localparam int CTL_SUPER_BIT = 16;
	localparam int CTL_SHWIN_BIT = 17;
	localparam int CTL_LPMASK_BIT = 18;
	// Screen config fields
	localparam int SCF_MW_LSB = 0;
	localparam int SCF_SRA_LSB = 16;
	localparam int SCF_SHIFT_LSB = 24;
	// Timing, zoom, cursor and light pen field positions
	localparam int HI_LSB = 16;
	localparam int HB_LSB = 8;
	localparam int ZM_ZY_LSB = 4;
	localparam int ZM_ROWS_LSB = 8;
	localparam int BC_END_LSB = 8;
	localparam int BC_WID_LSB = 16;
	localparam int LP_CHR_BIT = 20;

	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_HTIME = 32'h0000_4f63;
	localparam logic [31:0] RST_VTIME = 32'h01e0_020c;
	localparam logic [31:0] RST_SPLIT = 32'h0000_0000;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_ZOOM = 32'h0000_0f00;

	typedef enum logic [1:0] {
		DSC_CUR_BLOCK = 2'b00,
		DSC_CUR_GRAPHIC = 2'b01,
		DSC_CUR_CROSS = 2'b11
	} dsc_cmode_e;

	typedef enum logic [1:0] {
		DSC_SCAN_NONI = 2'b00,
		DSC_SCAN_ISYNC = 2'b01,
		DSC_SCAN_ISV = 2'b11
	} dsc_scan_e;
endpackage : dsc_pkg

/* dsc_pen_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_pen_sync (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic pen_strobe_in_i,
	output logic pulse_o
);
	logic meta;
	logic sync;
	logic sync_d;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
			sync_d <= 1'b0;
		end else begin
			meta <= pen_strobe_in_i;
			sync <= meta;
			sync_d <= sync;
		end
	end

	// One pulse per rising edge of the strobe
	assign pulse_o = sync & ~sync_d;

	property p_pen_single;
		@(posedge sys_clk_i) disable iff (reset_i) pulse_o |=> !pulse_o;
	endproperty
	a_pen_single: assert property (p_pen_single) else $error("pen pulse longer than one cycle");
endmodule : dsc_pen_sync
`default_nettype wire

/* dsc_cursor.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_cursor
	import dsc_pkg::*;
(
	input wire logic [HC_W-1:0] h_i,
	input wire logic [VC_W-1:0] v_i,
	input wire logic [CHR_AW-1:0] addr_i,
	input wire logic [RAS_W-1:0] ras_i,
	input wire logic chr_i,
	input wire logic [1:0] mode_i,
	input wire logic [31:0] bcur_a_i,
	input wire logic [31:0] bpos_a_i,
	input wire logic [31:0] bcur_b_i,
	input wire logic [31:0] bpos_b_i,
	input wire logic [31:0] gcur_x_i,
	input wire logic [31:0] gcur_y_i,
	output logic one_o,
	output logic two_o
);
	function automatic logic blk_hit(input logic [31:0] cfg, input logic [31:0] pos,
		input logic [CHR_AW-1:0] a, input logic [RAS_W-1:0] r);
		logic [CHR_AW-1:0] off;
		off = a - pos[CHR_AW-1:0];
		// Width field holds cycles minus one, so widths are 1..8
		blk_hit = (off <= {13'h0000, cfg[BC_WID_LSB+:3]}) && (r >= cfg[RAS_W-1:0]) &&
			(r <= cfg[BC_END_LSB+:RAS_W]);
	endfunction : blk_hit

	logic blk_a;
	logic blk_b;
	logic g_x;
	logic g_y;

	always_comb begin
		blk_a = chr_i && blk_hit(bcur_a_i, bpos_a_i, addr_i, ras_i);
		blk_b = chr_i && blk_hit(bcur_b_i, bpos_b_i, addr_i, ras_i);
		g_x = (h_i >= gcur_x_i[HC_W-1:0]) && (h_i <= gcur_x_i[HB_LSB+:HC_W]);
		g_y = (v_i >= gcur_y_i[VC_W-1:0]) && (v_i <= gcur_y_i[HI_LSB+:VC_W]);
		case (mode_i)
			DSC_CUR_GRAPHIC: begin
				one_o = g_x && g_y;
				two_o = blk_a || blk_b;
			end
			DSC_CUR_CROSS: begin
				one_o = g_y;
				two_o = g_x;
			end
			default: begin
				one_o = blk_a;
				two_o = blk_b;
			end
		endcase
	end
endmodule : dsc_cursor
`default_nettype wire

/* dsc_display_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_display_ctrl
	import dsc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic pen_strobe_in_i,
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic [RAS_W-1:0] raster_addr_o,
	output logic space_select_out_o,
	output logic disp_en_o,
	output logic hsync_o,
	output logic vsync_o,
	output logic field_o,
	output logic cursor_out_one_o,
	output logic cursor_out_two_o,
	output logic [3:0] dot_shift_o,
	output logic [3:0] zoom_x_o,
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] ctrl, htime, vtime, split, winh, winv, zoom;
	logic [31:0] bcur_a, bpos_a, bcur_b, bpos_b, gcur_x, gcur_y;
	logic [ADDR_W-1:0] screen_start_address_reg [4];
	logic [31:0] scfg [4];
	logic lp_flag;
	logic [ADDR_W-1:0] lp_addr;
	logic lp_chr;
	logic [31:0] rd_data;
	logic hit;
	logic acc_first;
	logic wr_done;
	logic stat_rd;
	logic next_lp_flag;

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a[1:0] == 2'b00) && ((a <= OFS_LPEN) || (a[7:5] == 3'b010));
	endfunction : reg_hit

	function automatic logic [ADDR_W-1:0] fmt_addr(input logic [ADDR_W-1:0] a, input logic chr);
		// Character space is 64k words; graphic space keeps all 20 bits
		fmt_addr = chr ? {4'h0, a[CHR_AW-1:0]} : a;
	endfunction : fmt_addr

	assign hit = reg_hit(paddr_i);
	assign acc_first = psel_i && penable_i && !pready_o;
	assign wr_done = psel_i && penable_i && pready_o && pwrite_i && hit;
	assign stat_rd = psel_i && penable_i && pready_o && !pwrite_i && (paddr_i == OFS_STAT);

	always_comb begin
		rd_data = 32'h0000_0000;
		if (paddr_i[7:5] == 3'b010) begin
			rd_data = paddr_i[2] ? scfg[paddr_i[4:3]] : {12'h000, screen_start_address_reg[paddr_i[4:3]]};
		end else begin
			case (paddr_i)
				OFS_CTRL: rd_data = ctrl;
				OFS_HTIME: rd_data = htime;
				OFS_VTIME: rd_data = vtime;
				OFS_SPLIT: rd_data = split;
				OFS_WINH: rd_data = winh;
				OFS_WINV: rd_data = winv;
				OFS_ZOOM: rd_data = zoom;
				OFS_BCUR_A: rd_data = bcur_a;
				OFS_BPOS_A: rd_data = bpos_a;
				OFS_BCUR_B: rd_data = bcur_b;
				OFS_BPOS_B: rd_data = bpos_b;
				OFS_GCUR_X: rd_data = gcur_x;
				OFS_GCUR_Y: rd_data = gcur_y;
				OFS_STAT: rd_data = {31'h0000_0000, lp_flag};
				OFS_LPEN: rd_data = {11'h000, lp_chr, lp_addr};
				default: rd_data = 32'h0000_0000;
			endcase
		end
	end

	// One wait cycle: pready rises on the second access-phase cycle
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= acc_first;
			pslverr_o <= acc_first && !hit;
			if (acc_first && !pwrite_i) begin
				prdata_o <= rd_data;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ctrl <= RST_CTRL;
			htime <= RST_HTIME;
			vtime <= RST_VTIME;
			split <= RST_SPLIT;
			winh <= RST_ZERO;
			winv <= RST_ZERO;
			zoom <= RST_ZOOM;
			bcur_a <= RST_ZERO;
			bpos_a <= RST_ZERO;
			bcur_b <= RST_ZERO;
			bpos_b <= RST_ZERO;
			gcur_x <= RST_ZERO;
			gcur_y <= RST_ZERO;
			for (int i = 0; i < 4; i++) begin
				screen_start_address_reg[i] <= '0;
				scfg[i] <= RST_ZERO;
			end
		end else if (wr_done) begin
			if (paddr_i[7:5] == 3'b010) begin
				if (paddr_i[2]) begin
					scfg[paddr_i[4:3]] <= pwdata_i;
				end else begin
					screen_start_address_reg[paddr_i[4:3]] <= pwdata_i[ADDR_W-1:0];
				end
			end else begin
				case (paddr_i)
					OFS_CTRL: ctrl <= pwdata_i;
					OFS_HTIME: htime <= pwdata_i;
					OFS_VTIME: vtime <= pwdata_i;
					OFS_SPLIT: split <= pwdata_i;
					OFS_WINH: winh <= pwdata_i;
					OFS_WINV: winv <= pwdata_i;
					OFS_ZOOM: zoom <= pwdata_i;
					OFS_BCUR_A: bcur_a <= pwdata_i;
					OFS_BPOS_A: bpos_a <= pwdata_i;
					OFS_BCUR_B: bcur_b <= pwdata_i;
					OFS_BPOS_B: bpos_b <= pwdata_i;
					OFS_GCUR_X: gcur_x <= pwdata_i;
					OFS_GCUR_Y: gcur_y <= pwdata_i;
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Raster timing
	logic [HC_W-1:0] h;
	logic [VC_W-1:0] v;
	logic field;
	logic eol;
	logic eof;
	logic [1:0] scan;
	logic isv;
	logic super_m;
	logic [3:0] zx;
	logic [3:0] zy;
	logic [RAS_W-1:0] ch_rows;

	assign scan = ctrl[CTL_SCAN_LSB+:2];
	assign isv = (scan == DSC_SCAN_ISV);
	assign super_m = ctrl[CTL_SUPER_BIT];
	assign zx = zoom[3:0];
	assign zy = zoom[ZM_ZY_LSB+:4];
	assign ch_rows = zoom[ZM_ROWS_LSB+:RAS_W];
	assign eol = (h == htime[HC_W-1:0]);
	assign eof = eol && (v == vtime[VC_W-1:0]);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			h <= '0;
			v <= '0;
			field <= 1'b0;
		end else begin
			h <= eol ? '0 : h + 1'b1;
			if (eol) begin
				v <= eof ? '0 : v + 1'b1;
			end
			if (eof) begin
				field <= (scan != DSC_SCAN_NONI) && !field;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Screen selection
	logic v_disp;
	logic h_disp;
	logic [1:0] bg_idx;
	logic bg_on;
	logic win_row;
	logic win_on;
	logic use_win;
	logic [1:0] cur_idx;
	logic [3:0] chr;
	logic [ADDR_W-1:0] line_base [4];
	logic [RAS_W-1:0] ras [4];
	logic [3:0] vzc;
	logic [ADDR_W-1:0] bg_addr;
	logic [ADDR_W-1:0] win_addr;
	logic [ADDR_W-1:0] pen_addr;
	logic pen_chr;
	logic pen_pulse;
	logic cur_one;
	logic cur_two;

	assign chr = ctrl[CTL_CHR_LSB+:4];
	assign v_disp = v < vtime[HI_LSB+:VC_W];
	assign h_disp = h < htime[HB_LSB+:HC_W];
	assign bg_idx = (v < split[VC_W-1:0]) ? 2'd0 : (v < split[HI_LSB+:VC_W]) ? 2'd1 : 2'd2;
	// Base always shows; upper and lower only when enabled
	assign bg_on = v_disp && h_disp && ((bg_idx == 2'd1) || ctrl[CTL_EN_LSB + ((bg_idx == 2'd0) ? 0 : 1)]);
	assign win_row = ctrl[CTL_EN_LSB+2] && (v >= winv[VC_W-1:0]) && (v <= winv[HI_LSB+:VC_W]);
	assign win_on = win_row && h_disp && (h >= winh[HC_W-1:0]) && (h <= winh[HB_LSB+:HC_W]);
	// Superimposed mode interleaves: odd cycles fetch the window, even the background
	assign use_win = win_on && (!super_m || h[0]);
	assign cur_idx = use_win ? 2'd3 : bg_idx;
	assign bg_addr = line_base[bg_idx] + {12'h000, h};
	assign win_addr = line_base[3] + {12'h000, h - winh[HC_W-1:0]};
	assign pen_addr = (win_on && !super_m) ? win_addr : bg_addr;
	assign pen_chr = (win_on && !super_m) ? chr[3] : chr[bg_idx];

	// Per-screen line start and raster counters
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			vzc <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				line_base[i] <= '0;
				ras[i] <= '0;
			end
		end else if (eof) begin
			vzc <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				// Odd field of interlace video starts one line or raster down
				if (isv && !field && !chr[i]) begin
					line_base[i] <= screen_start_address_reg[i] + {4'h0, scfg[i][SCF_MW_LSB+:16]};
				end else begin
					line_base[i] <= screen_start_address_reg[i];
				end
				ras[i] <= scfg[i][SCF_SRA_LSB+:RAS_W] + {4'h0, isv && !field && chr[i]};
			end
		end else if (eol) begin
			if (v_disp && (bg_idx == 2'd1)) begin
				vzc <= (vzc == zy) ? 4'h0 : vzc + 4'h1;
			end
			for (int i = 0; i < 4; i++) begin
				if ((i == 3) ? win_row : (v_disp && (bg_idx == 2'(i)) && (i != 1 || vzc == zy))) begin
					if (chr[i]) begin
						if ({1'b0, ras[i]} + {4'h0, isv} + 6'h01 > {1'b0, ch_rows}) begin
							ras[i] <= ras[i] + {4'h0, isv} - ch_rows;
							line_base[i] <= line_base[i] + {4'h0, scfg[i][SCF_MW_LSB+:16]};
						end else begin
							ras[i] <= ras[i] + {4'h0, isv} + 5'h01;
						end
					end else begin
						line_base[i] <= line_base[i] + ({4'h0, scfg[i][SCF_MW_LSB+:16]} << isv);
					end
				end
			end
		end
	end

	dsc_cursor u_cursor (
		.h_i(h),
		.v_i(v),
		.addr_i(use_win ? win_addr[CHR_AW-1:0] : bg_addr[CHR_AW-1:0]),
		.ras_i(ras[cur_idx]),
		.chr_i(chr[cur_idx]),
		.mode_i(ctrl[CTL_CMODE_LSB+:2]),
		.bcur_a_i(bcur_a),
		.bpos_a_i(bpos_a),
		.bcur_b_i(bcur_b),
		.bpos_b_i(bpos_b),
		.gcur_x_i(gcur_x),
		.gcur_y_i(gcur_y),
		.one_o(cur_one),
		.two_o(cur_two)
	);

	dsc_pen_sync u_pen (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.pen_strobe_in_i(pen_strobe_in_i),
		.pulse_o(pen_pulse)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Video outputs
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mem_addr_o <= '0;
			raster_addr_o <= '0;
			space_select_out_o <= 1'b0;
			disp_en_o <= 1'b0;
			hsync_o <= 1'b0;
			vsync_o <= 1'b0;
			field_o <= 1'b0;
			cursor_out_one_o <= 1'b0;
			cursor_out_two_o <= 1'b0;
			dot_shift_o <= 4'h0;
			zoom_x_o <= 4'h0;
		end else begin
			mem_addr_o <= fmt_addr(use_win ? win_addr : bg_addr, chr[cur_idx]);
			raster_addr_o <= chr[cur_idx] ? ras[cur_idx] : '0;
			space_select_out_o <= chr[cur_idx];
			disp_en_o <= (bg_on || win_on) && !ctrl[CTL_BLANK_LSB + 32'(cur_idx)];
			hsync_o <= !h_disp;
			vsync_o <= !v_disp;
			field_o <= field;
			cursor_out_one_o <= cur_one;
			cursor_out_two_o <= cur_two;
			// Only one source of dot shift per raster: window or the backgrounds
			if (ctrl[CTL_SHWIN_BIT]) begin
				dot_shift_o <= use_win ? scfg[3][SCF_SHIFT_LSB+:4] : 4'h0;
			end else begin
				dot_shift_o <= (bg_on && !use_win) ? scfg[bg_idx][SCF_SHIFT_LSB+:4] : 4'h0;
			end
			zoom_x_o <= (bg_on && cur_idx == 2'd1) ? zx : 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Light pen
	// A capture in the same cycle as the clearing read keeps the flag set
	assign next_lp_flag = pen_pulse || (lp_flag && !stat_rd);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			lp_flag <= 1'b0;
			lp_addr <= '0;
			lp_chr <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			lp_flag <= next_lp_flag;
			irq_o <= next_lp_flag && ctrl[CTL_LPMASK_BIT];
			if (pen_pulse) begin
				lp_addr <= fmt_addr(pen_addr, pen_chr);
				lp_chr <= pen_chr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	property p_lp_capture;
		pen_pulse |=> (lp_addr == fmt_addr($past(pen_addr), $past(pen_chr))) && (lp_chr == $past(pen_chr));
	endproperty
	a_lp_capture: assert property (p_lp_capture) else $error("pen address not captured");

	property p_lp_irq;
		pen_pulse && ctrl[CTL_LPMASK_BIT] && !wr_done |=>
			lp_flag && irq_o ##1 (irq_o || $past(stat_rd) || $past(wr_done));
	endproperty
	a_lp_irq: assert property (p_lp_irq) else $error("pen flag or interrupt missing");

	property p_clear;
		stat_rd && !pen_pulse |=> !lp_flag && !irq_o;
	endproperty
	a_clear: assert property (p_clear) else $error("status read did not withdraw interrupt");

	property p_super_bg;
		pen_pulse && win_on && super_m |=> lp_addr == fmt_addr($past(bg_addr), $past(chr[bg_idx]));
	endproperty
	a_super_bg: assert property (p_super_bg) else $error("overlap capture not background");

	property p_win_prio;
		win_on && !super_m |=> space_select_out_o == $past(chr[3]) && mem_addr_o == fmt_addr($past(win_addr), $past(chr[3]));
	endproperty
	a_win_prio: assert property (p_win_prio) else $error("window lost priority");

	property p_chr_space;
		space_select_out_o |-> mem_addr_o[ADDR_W-1:CHR_AW] == 4'h0;
	endproperty
	a_chr_space: assert property (p_chr_space) else $error("character address exceeds 64k");

	property p_noni_field;
		eof && scan == DSC_SCAN_NONI |=> ##1 !field_o;
	endproperty
	a_noni_field: assert property (p_noni_field) else $error("field toggled in non-interlace");

	property p_zoom_x;
		bg_on && cur_idx == 2'd1 |=> zoom_x_o == $past(zx);
	endproperty
	a_zoom_x: assert property (p_zoom_x) else $error("zoom attribute wrong");

	property p_vzoom;
		eol && !eof && v_disp && bg_idx == 2'd1 && vzc != zy |=> $stable(line_base[1]) && $stable(ras[1]);
	endproperty
	a_vzoom: assert property (p_vzoom) else $error("base advanced before zoom count");

	c_capture: cover property (pen_pulse ##1 lp_flag);
	c_window: cover property (win_on && !super_m);
	c_odd_field: cover property (isv && field && eol);
endmodule : dsc_display_ctrl
`default_nettype wire

/* dsc_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_far_side (
	input wire logic sys_clk_i,
	input wire logic fire_i,
	input wire logic [3:0] hold_i,
	input wire logic [3:0] zoom_x_i,
	input wire logic space_select_i,
	input wire logic disp_en_i,
	output logic pen_strobe_o,
	output logic shift_tick_o,
	output logic chr_sel_o,
	output logic gfx_sel_o
);
	logic [3:0] run = 4'h0;
	logic [3:0] div = 4'h0;
	logic strobe = 1'b0;

	////////////////////////////////////////////////////////////////
	// Pen stays low three cycles after each pulse for hold_i up to 12, so captures never merge
	always @(posedge sys_clk_i) begin
		if (run != 4'h0) begin
			run <= run - 4'h1;
			strobe <= run > 4'h3;
		end else if (fire_i) begin
			run <= hold_i + 4'h3;
			strobe <= 1'b1;
		end
	end
	assign pen_strobe_o = strobe;

	////////////////////////////////////////////////////////////////
	// Shift register load conditioned by the zoom attribute
	always @(posedge sys_clk_i) begin
		div <= (div >= zoom_x_i) ? 4'h0 : div + 4'h1;
	end
	assign shift_tick_o = (div == 4'h0);
	assign chr_sel_o = disp_en_i & space_select_i;
	assign gfx_sel_o = disp_en_i & ~space_select_i;
endmodule : dsc_far_side
`default_nettype wire

/* display_screen_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module display_screen_control_bench
	import dsc_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic fire = 1'b0;
	logic [3:0] hold = 4'h1;
	logic [31:0] prdata;
	logic pready, pslverr, pen, space_sel, disp_en, field, irq;
	logic shift_tick, chr_sel, gfx_sel;
	logic hsync, vsync, cur1, cur2;
	// Previous sync levels and a flag for the first displayed line
	logic hs_p = 1'b0;
	logic vs_p = 1'b0;
	logic line0 = 1'b0;
	logic [ADDR_W-1:0] mem_addr;
	logic [RAS_W-1:0] raster;
	logic [3:0] dot_shift, zoom_x;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	// Each note: write flag, expected error, read mask, expected data
	logic [65:0] notes[$];
	logic [65:0] n;

	initial begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	dsc_display_ctrl u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .pen_strobe_in_i(pen), .mem_addr_o(mem_addr), .raster_addr_o(raster),
		.space_select_out_o(space_sel), .disp_en_o(disp_en), .hsync_o(hsync), .vsync_o(vsync), .field_o(field),
		.cursor_out_one_o(cur1), .cursor_out_two_o(cur2), .dot_shift_o(dot_shift), .zoom_x_o(zoom_x),
		.irq_o(irq));

	dsc_far_side u_far (.sys_clk_i(sys_clk_i), .fire_i(fire), .hold_i(hold), .zoom_x_i(zoom_x),
		.space_select_i(space_sel), .disp_en_i(disp_en), .pen_strobe_o(pen), .shift_tick_o(shift_tick),
		.chr_sel_o(chr_sel), .gfx_sel_o(gfx_sel));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			failures++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err,
		input logic [31:0] msk, input logic [31:0] exp);
		notes.push_back({wr, err, msk, exp});
		@(posedge sys_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do @(posedge sys_clk_i); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 32'h0, 32'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 1'b0, 32'hffff_ffff, exp);
	endtask : rd

	task automatic fire_pen(input logic [3:0] h);
		repeat ($urandom_range(0, 7)) @(posedge sys_clk_i);
		do @(posedge sys_clk_i); while (disp_en !== 1'b1);
		hold <= h;
		fire <= 1'b1;
		@(posedge sys_clk_i);
		fire <= 1'b0;
	endtask : fire_pen

	// Settles one whole frame first so a new setting is in force everywhere
	task automatic watch(input int cnt, input logic chr, input logic [3:0] zx, input logic [3:0] ds,
		input logic blank, input logic il, input logic [1:0] cmd);
		int shown, flips, bz, bs, bd, bc;
		logic last, hf, l0;
		shown = 0;
		bc = 0;
		flips = 0;
		bz = 0;
		bs = 0;
		bd = 0;
		repeat (340) @(posedge sys_clk_i);
		last = field;
		repeat (cnt) begin
			@(posedge sys_clk_i);
			flips += (field !== last);
			last = field;
			// Graphic cursor registers stay at zero: column 0 and raster line 0 only
			hf = hs_p && !hsync;
			l0 = (vs_p && !vsync) || (line0 && !hf);
			case (cmd)
				DSC_CUR_CROSS: bc += (cur1 !== l0) || (cur2 !== hf);
				DSC_CUR_GRAPHIC: bc += (cur1 !== (hf && l0));
				default: bc += (cur1 !== 1'b0) || (cur2 !== 1'b0);
			endcase
			if (disp_en === 1'b1) begin
				shown++;
				bz += (zoom_x !== zx);
				bd += (dot_shift !== ds);
				bs += (space_sel !== chr) || (chr ? mem_addr[ADDR_W-1:CHR_AW] !== 4'h0 : raster !== 5'h0);
				bs += (chr_sel !== chr) || (gfx_sel === chr);
			end
		end
		chk(blank ? shown == 0 : shown > 0, "display enable");
		chk(bz == 0, "zoom attribute");
		chk(bd == 0, "dot shift attribute");
		chk(bs == 0, "space select or address range");
		chk(il ? flips >= 2 : (flips == 0 && field === 1'b0), "field sequence");
		chk(bc == 0, "cursor outputs");
	endtask : watch

	////////////////////////////////////////////////////////////////
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		hs_p <= hsync;
		vs_p <= vsync;
		line0 <= (vs_p && !vsync) || (line0 && !(hs_p && !hsync));
		if (pready === 1'b1) begin
			n = notes.size() > 0 ? notes.pop_front() : {2'b01, 64'h0};
			chk(pslverr === n[64] && (n[65] || (prdata & n[63:32]) === n[31:0]), "response or read data");
		end
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end

	initial begin
		logic [31:0] v;
		logic [31:0] ctl;
		logic [3:0] zx;
		logic [3:0] ds;
		dsc_scan_e sc[3];
		dsc_cmode_e cm[3];
		sc = '{DSC_SCAN_NONI, DSC_SCAN_ISYNC, DSC_SCAN_ISV};
		cm = '{DSC_CUR_BLOCK, DSC_CUR_GRAPHIC, DSC_CUR_CROSS};
		void'($urandom(32));
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(OFS_CTRL, RST_CTRL);
		rd(OFS_HTIME, RST_HTIME);
		rd(OFS_VTIME, RST_VTIME);
		rd(OFS_ZOOM, RST_ZOOM);
		rd(OFS_STAT, RST_ZERO);
		apb(1'b0, 8'hfc, 32'h0, 1'b1, 32'hffff_ffff, 32'h0);
		apb(1'b1, 8'h02, 32'hffff_ffff, 1'b1, 32'h0, 32'h0);
		rd(OFS_CTRL, RST_CTRL);
		v = $urandom() & 32'h000f_ffff;
		wr(OFS_SCR_BASE + 8'h08, v);
		rd(OFS_SCR_BASE + 8'h08, v);
		// Short frame: 16 columns by 20 rows keeps each frame at 320 cycles
		wr(OFS_HTIME, 32'h0000_0c0f);
		wr(OFS_VTIME, 32'h0010_0013);
		wr(OFS_SPLIT, 32'h03ff_0000);
		for (int i = 0; i < 3; i++) begin
			zx = 4'($urandom());
			ds = 4'($urandom());
			wr(OFS_ZOOM, {19'h0, 5'h03, 4'h1, zx});
			rd(OFS_ZOOM, {19'h0, 5'h03, 4'h1, zx});
			wr(OFS_SCR_BASE + 8'h0c, {4'h0, ds, 8'h0, 16'h0010});
			ctl = 32'h0;
			ctl[15:14] = sc[i];
			ctl[13:12] = cm[i];
			ctl[9] = i[0];
			wr(OFS_CTRL, ctl);
			watch(700, i[0], zx, ds, 1'b0, i != 0, cm[i]);
		end
		ctl[5] = 1'b1;
		wr(OFS_CTRL, ctl);
		watch(700, ctl[9], zx, ds, 1'b1, 1'b1, cm[2]);
		// Window over the base screen, plain and superimposed; zoom and shift zero there
		wr(OFS_ZOOM, 32'h0000_0300);
		wr(OFS_SCR_BASE + 8'h0c, 32'h0000_0010);
		wr(OFS_WINH, 32'h0000_0502);
		wr(OFS_WINV, 32'h0005_0002);
		for (int s = 0; s < 2; s++) begin
			wr(OFS_CTRL, {15'h0, s[0], 16'h0004});
			watch(700, 1'b0, 4'h0, 4'h0, 1'b0, 1'b0, DSC_CUR_BLOCK);
		end
		for (int m = 0; m < 2; m++) begin
			wr(OFS_CTRL, {13'h0, m[0], 6'h0, {4{m[0]}}, 8'h0});
			fire_pen(4'h1);
			repeat (10) @(posedge sys_clk_i);
			chk(irq === m[0], "pen interrupt level");
			rd(OFS_STAT, 32'h1);
			repeat (2) @(posedge sys_clk_i);
			chk(irq === 1'b0, "interrupt withdrawn");
			rd(OFS_STAT, RST_ZERO);
			apb(1'b0, OFS_LPEN, 32'h0, 1'b0, 32'hfff0_0000, {11'h0, m[0], 20'h0});
		end
		fire_pen(4'h8);
		repeat (5) @(posedge sys_clk_i);
		rd(OFS_STAT, 32'h1);
		repeat (12) @(posedge sys_clk_i);
		rd(OFS_STAT, RST_ZERO);
		repeat (4) @(posedge sys_clk_i);
		tally_and_finish();
	end
endmodule : display_screen_control_bench
`default_nettype wire
